// ==== lp4_mr_sr_map.svh ====
// Command codes, mode register layout and timing counts of the mode register and self refresh unit.
`ifndef LP4_MR_SR_MAP_SVH
`define LP4_MR_SR_MAP_SVH

// First-cycle command codes on ca[4:0] while cs is high.
`define CMD_SRE          5'h18
`define CMD_SRX          5'h14
`define CMD_MRW1         5'h06
`define CMD_MRW2         5'h16
`define CMD_MRR1         5'h0e
`define CMD_CAS2         5'h12
`define CMD_REF          5'h08
// Flag bit on the first command cycle: all-bank refresh, and the upper data bits of an MRW.
`define CA_FLAG_BIT      5
`define EXTRA_PB_COUNT   4'h8

// Mode register layout.
`define MR_COUNT         64
`define MR_RESET         8'h00
`define MR_ABORT_ADDR    6'h04
`define MR_ABORT_BIT     3
`define MR_DATA_UI       4'h4
`define MR_LAST_BEAT     4'hf
`define MR_BYTE_HI       7
`define MR_BYTE_NEXT     6
// Read-only registers: the lowest one, and a contiguous span further up.
`define MR_RO_SINGLE     6'h00
`define MR_RO_FIRST      6'h05
`define MR_RO_LAST       6'h08

// Density of this part and the least density that offers self refresh abort.
`define DENSITY_GB       8
`define ABORT_MIN_GB     12

// Timing.
`define CLK_PERIOD_NS    5
`define RL_CYC           14
`define TREFI_NS         3904
`define TRFCAB_NS        280
`define SR_REF_CYC       ((`TREFI_NS) / (`CLK_PERIOD_NS))
`define RFCAB_CYC        ((`TRFCAB_NS + `CLK_PERIOD_NS - 1) / (`CLK_PERIOD_NS))

`endif

// ==== lp4_mr_sr_pkg.sv ====
// Types of the mode register and self refresh unit.
package lp4_mr_sr_pkg;

    typedef enum logic [0:0] {
        SR_OFF = 1'b0,
        SR_ON  = 1'b1
    } sr_state_type;

    typedef enum logic [2:0] {
        RD_IDLE  = 3'b000,
        RD_WAIT  = 3'b001,
        RD_PRE   = 3'b010,
        RD_BURST = 3'b011,
        RD_POST  = 3'b100
    } rd_phase_type;

    typedef struct packed {
        logic       cke;
        logic       cs;
        logic [5:0] ca;
    } cmd_pins_type;

    typedef struct packed {
        logic [15:0] dq;
        logic        dq_oe;
        logic        dqs;
        logic        dqs_oe;
        logic        dmi;
        logic        dmi_oe;
    } rd_bus_type;

endpackage : lp4_mr_sr_pkg

// ==== lp4_mr_sr.sv ====
// Mode register read/write and self refresh with abort for one channel.
//
// Operation
// - With abort enabled, exit cancels running refresh and keeps refresh counter.
// - Self refresh abort exists only on parts of 12 Gb and larger.
// - Mode register commands accepted during tXSR and during refresh.
// - Register read decodes a 6-bit address selecting one of 64 registers.
// - Register byte on dq[7:0] for first 4 beats, read latency after command.
// - Register read burst is 16 beats, strobe toggles with read preamble/postamble.
// - Without inversion on register reads, dmi is held low during the burst.
// - A write to a read-only register changes nothing.
// - Register write accepted with banks idle or active, bank state unchanged.
`timescale 1ns/1ps
`default_nettype none
`include "lp4_mr_sr_map.svh"

module lp4_mr_sr (
    // Clock and reset.
    input  wire logic                        clk,
    input  wire logic                        sys_rst,
    // Command pins from the controller.
    input  wire lp4_mr_sr_pkg::cmd_pins_type cmd_pins,
    // Read data pins towards the controller.
    output var  lp4_mr_sr_pkg::rd_bus_type   rd_bus,
    // Status.
    output var  logic                        in_self_refresh,
    output var  logic                        refresh_busy,
    output var  logic [15:0]                 refresh_count,
    output var  logic                        extra_ref_needed
);

    localparam int RD_DLY = `RL_CYC + 2;

    // A few read-only registers; writes to them are dropped.
    function automatic logic is_read_only(input logic [5:0] addr);
        is_read_only = (addr == `MR_RO_SINGLE) || (addr >= `MR_RO_FIRST && addr <= `MR_RO_LAST);
    endfunction : is_read_only

    lp4_mr_sr_pkg::cmd_pins_type pins_s1_ff;
    lp4_mr_sr_pkg::cmd_pins_type pins_s2_ff;

    // Two-stage synchroniser on the command pins.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pins_s1_ff <= '0;
            pins_s2_ff <= '0;
        end else begin
            pins_s1_ff <= cmd_pins;
            pins_s2_ff <= pins_s1_ff;
        end
    end

    // Command decode: first cycle with cs high, second with cs low.
    logic       first_vld_ff;
    logic [5:0] first_ca_ff;
    logic       nxt_first_vld;
    logic [5:0] nxt_first_ca;
    logic       cmd_done;
    logic [4:0] cmd_op;
    logic       cmd_flag;
    logic [5:0] cmd_arg;

    always_comb begin
        nxt_first_vld = pins_s2_ff.cke && pins_s2_ff.cs;
        nxt_first_ca  = pins_s2_ff.cs ? pins_s2_ff.ca : first_ca_ff;
        cmd_done      = first_vld_ff && pins_s2_ff.cke && !pins_s2_ff.cs;
        cmd_op        = first_ca_ff[4:0];
        cmd_flag      = first_ca_ff[`CA_FLAG_BIT];
        cmd_arg       = pins_s2_ff.ca;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            first_vld_ff <= 1'b0;
            first_ca_ff  <= '0;
        end else begin
            first_vld_ff <= nxt_first_vld;
            first_ca_ff  <= nxt_first_ca;
        end
    end

    // Mode register array and write path.
    logic [7:0] mr_ff [`MR_COUNT];
    logic [5:0] mrw_ma_ff;
    logic       mrw_hi_ff;
    logic [5:0] nxt_mrw_ma;
    logic       nxt_mrw_hi;
    logic       mr_we;
    logic [7:0] mr_wdata;
    logic       abort_on;

    always_comb begin
        nxt_mrw_ma = mrw_ma_ff;
        nxt_mrw_hi = mrw_hi_ff;
        mr_we      = 1'b0;
        mr_wdata   = {mrw_hi_ff, cmd_flag, cmd_arg};
        if (cmd_done && cmd_op == `CMD_MRW1) begin
            nxt_mrw_ma = cmd_arg;
            nxt_mrw_hi = cmd_flag;
        end
        // Taken in any refresh or bank state; bank state is not touched here.
        if (cmd_done && cmd_op == `CMD_MRW2) begin
            mr_we = !is_read_only(mrw_ma_ff);
        end
        abort_on = (`DENSITY_GB >= `ABORT_MIN_GB)
            && mr_ff[`MR_ABORT_ADDR][`MR_ABORT_BIT];
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mrw_ma_ff <= '0;
            mrw_hi_ff <= 1'b0;
            for (int i = 0; i < `MR_COUNT; i++) begin
                mr_ff[i] <= `MR_RESET;
            end
        end else begin
            mrw_ma_ff <= nxt_mrw_ma;
            mrw_hi_ff <= nxt_mrw_hi;
            if (mr_we) begin
                mr_ff[mrw_ma_ff] <= mr_wdata;
            end
        end
    end

    // Self refresh and internal refresh engine.
    lp4_mr_sr_pkg::sr_state_type sr_state_ff;
    lp4_mr_sr_pkg::sr_state_type nxt_sr_state;
    logic [9:0]  ref_tmr_ff;
    logic [9:0]  nxt_ref_tmr;
    logic [5:0]  rfc_tmr_ff;
    logic [5:0]  nxt_rfc_tmr;
    logic        nxt_ref_busy;
    logic [15:0] nxt_ref_count;
    logic        nxt_extra_ref;
    logic [3:0]  pb_cnt_ff;
    logic [3:0]  nxt_pb_cnt;
    logic        ref_start;
    logic        is_srx;

    always_comb begin
        nxt_sr_state  = sr_state_ff;
        nxt_ref_tmr   = ref_tmr_ff;
        nxt_rfc_tmr   = rfc_tmr_ff;
        nxt_ref_busy  = refresh_busy;
        nxt_ref_count = refresh_count;
        nxt_extra_ref = extra_ref_needed;
        nxt_pb_cnt    = pb_cnt_ff;
        ref_start     = 1'b0;
        is_srx        = cmd_done && cmd_op == `CMD_SRX && sr_state_ff == lp4_mr_sr_pkg::SR_ON;
        case (sr_state_ff)
            lp4_mr_sr_pkg::SR_OFF: begin
                if (cmd_done && cmd_op == `CMD_SRE) begin
                    nxt_sr_state = lp4_mr_sr_pkg::SR_ON;
                    nxt_ref_tmr  = '0;
                end
            end
            lp4_mr_sr_pkg::SR_ON: begin
                if (ref_tmr_ff == 10'(`SR_REF_CYC - 1)) begin
                    nxt_ref_tmr = '0;
                    ref_start   = !refresh_busy;
                end else begin
                    nxt_ref_tmr = ref_tmr_ff + 10'h001;
                end
                if (is_srx) begin
                    nxt_sr_state = lp4_mr_sr_pkg::SR_OFF;
                end
            end
            default: nxt_sr_state = lp4_mr_sr_pkg::SR_OFF;
        endcase
        if (ref_start) begin
            nxt_ref_busy = 1'b1;
            nxt_rfc_tmr  = 6'(`RFCAB_CYC - 1);
        end else if (refresh_busy) begin
            if (rfc_tmr_ff == 6'h00) begin
                nxt_ref_busy  = 1'b0;
                nxt_ref_count = refresh_count + 16'h0001;
            end else begin
                nxt_rfc_tmr = rfc_tmr_ff - 6'h01;
            end
        end
        // Abort drops the running refresh without counting it.
        if (is_srx && abort_on) begin
            nxt_ref_busy  = 1'b0;
            nxt_ref_count = refresh_count;
        end
        // Extra refresh owed after exit; one command per cycle, so set and clear never meet.
        if (cmd_done && cmd_op == `CMD_REF && extra_ref_needed) begin
            if (cmd_flag || pb_cnt_ff == `EXTRA_PB_COUNT - 4'h1) begin
                nxt_extra_ref = 1'b0;
                nxt_pb_cnt    = '0;
            end else begin
                nxt_pb_cnt = pb_cnt_ff + 4'h1;
            end
        end
        if (is_srx) begin
            nxt_extra_ref = 1'b1;
            nxt_pb_cnt    = '0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sr_state_ff      <= lp4_mr_sr_pkg::SR_OFF;
            in_self_refresh  <= 1'b0;
            ref_tmr_ff       <= '0;
            rfc_tmr_ff       <= '0;
            refresh_busy     <= 1'b0;
            refresh_count    <= '0;
            extra_ref_needed <= 1'b0;
            pb_cnt_ff        <= '0;
        end else begin
            sr_state_ff      <= nxt_sr_state;
            in_self_refresh  <= nxt_sr_state == lp4_mr_sr_pkg::SR_ON;
            ref_tmr_ff       <= nxt_ref_tmr;
            rfc_tmr_ff       <= nxt_rfc_tmr;
            refresh_busy     <= nxt_ref_busy;
            refresh_count    <= nxt_ref_count;
            extra_ref_needed <= nxt_extra_ref;
            pb_cnt_ff        <= nxt_pb_cnt;
        end
    end

    // Mode register read path: latency, preamble, 16 beats, postamble.
    lp4_mr_sr_pkg::rd_phase_type rd_phase_ff;
    lp4_mr_sr_pkg::rd_phase_type nxt_rd_phase;
    lp4_mr_sr_pkg::rd_bus_type   nxt_rd_bus;
    logic [4:0] rd_tmr_ff;
    logic [4:0] nxt_rd_tmr;
    logic [3:0] beat_ff;
    logic [3:0] nxt_beat;
    logic [7:0] rd_data_ff;
    logic [7:0] nxt_rd_data;
    logic       mrr_pend_ff;
    logic       nxt_mrr_pend;
    logic [5:0] mrr_ma_ff;
    logic [5:0] nxt_mrr_ma;
    logic       rd_launch;

    always_comb begin
        nxt_rd_phase = rd_phase_ff;
        nxt_rd_tmr   = rd_tmr_ff;
        nxt_beat     = beat_ff;
        nxt_rd_data  = rd_data_ff;
        nxt_mrr_pend = mrr_pend_ff;
        nxt_mrr_ma   = mrr_ma_ff;
        rd_launch    = 1'b0;
        if (cmd_done && cmd_op == `CMD_MRR1) begin
            nxt_mrr_pend = 1'b1;
            nxt_mrr_ma   = cmd_arg;
        end
        // A read arriving during a running burst is dropped.
        if (cmd_done && cmd_op == `CMD_CAS2 && mrr_pend_ff) begin
            nxt_mrr_pend = 1'b0;
            rd_launch    = rd_phase_ff == lp4_mr_sr_pkg::RD_IDLE;
        end
        case (rd_phase_ff)
            lp4_mr_sr_pkg::RD_IDLE: begin
                if (rd_launch) begin
                    nxt_rd_phase = lp4_mr_sr_pkg::RD_WAIT;
                    nxt_rd_tmr   = 5'(`RL_CYC - 2);
                    nxt_rd_data  = mr_ff[mrr_ma_ff];
                end
            end
            lp4_mr_sr_pkg::RD_WAIT: begin
                if (rd_tmr_ff == 5'h00) begin
                    nxt_rd_phase = lp4_mr_sr_pkg::RD_PRE;
                end else begin
                    nxt_rd_tmr = rd_tmr_ff - 5'h01;
                end
            end
            lp4_mr_sr_pkg::RD_PRE: begin
                nxt_rd_phase = lp4_mr_sr_pkg::RD_BURST;
                nxt_beat     = '0;
            end
            lp4_mr_sr_pkg::RD_BURST: begin
                if (beat_ff == `MR_LAST_BEAT) begin
                    nxt_rd_phase = lp4_mr_sr_pkg::RD_POST;
                end else begin
                    nxt_beat = beat_ff + 4'h1;
                end
            end
            lp4_mr_sr_pkg::RD_POST: nxt_rd_phase = lp4_mr_sr_pkg::RD_IDLE;
            default:                nxt_rd_phase = lp4_mr_sr_pkg::RD_IDLE;
        endcase
        nxt_rd_bus        = '0;
        nxt_rd_bus.dq_oe  = rd_phase_ff == lp4_mr_sr_pkg::RD_BURST;
        nxt_rd_bus.dqs_oe = rd_phase_ff == lp4_mr_sr_pkg::RD_PRE || nxt_rd_bus.dq_oe
            || rd_phase_ff == lp4_mr_sr_pkg::RD_POST;
        nxt_rd_bus.dqs    = nxt_rd_bus.dqs_oe && !rd_bus.dqs;
        nxt_rd_bus.dmi_oe = nxt_rd_bus.dq_oe;
        nxt_rd_bus.dmi    = 1'b0;
        if (nxt_rd_bus.dq_oe && beat_ff < `MR_DATA_UI) begin
            nxt_rd_bus.dq[7:0] = rd_data_ff;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_phase_ff <= lp4_mr_sr_pkg::RD_IDLE;
            rd_tmr_ff   <= '0;
            beat_ff     <= '0;
            rd_data_ff  <= '0;
            mrr_pend_ff <= 1'b0;
            mrr_ma_ff   <= '0;
            rd_bus      <= '0;
        end else begin
            rd_phase_ff <= nxt_rd_phase;
            rd_tmr_ff   <= nxt_rd_tmr;
            beat_ff     <= nxt_beat;
            rd_data_ff  <= nxt_rd_data;
            mrr_pend_ff <= nxt_mrr_pend;
            mrr_ma_ff   <= nxt_mrr_ma;
            rd_bus      <= nxt_rd_bus;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence burst_16;
        rd_bus.dq_oe [*8] ##1 rd_bus.dq_oe [*8];
    endsequence

    a_mrr_burst_len: assert property ($rose(rd_bus.dq_oe) |-> burst_16 ##1 !rd_bus.dq_oe)
        else $error("register read burst is not 16 beats");
    a_mrr_latency: assert property (rd_launch |-> ##RD_DLY $rose(rd_bus.dq_oe))
        else $error("register read data late or early");
    a_mrr_data_ui: assert property ($rose(rd_bus.dq_oe) |-> ##3
        (rd_bus.dq[7:0] == $past(rd_bus.dq[7:0], 3)) ##1 (rd_bus.dq[7:0] == 8'h00))
        else $error("register byte not held for four beats");
    a_dmi_low: assert property (rd_bus.dq_oe |-> rd_bus.dmi_oe && !rd_bus.dmi)
        else $error("dmi not held low in register read");
    a_dqs_toggle: assert property (rd_bus.dqs_oe && $past(rd_bus.dqs_oe)
        |-> rd_bus.dqs != $past(rd_bus.dqs))
        else $error("strobe stopped toggling");
    a_ro_kept: assert property (cmd_done && cmd_op == `CMD_MRW2 && is_read_only(mrw_ma_ff)
        |=> $stable(mr_ff[mrw_ma_ff]))
        else $error("read-only register changed");
    a_mrw_in_ref: assert property (mr_we && refresh_busy
        |=> mr_ff[$past(mrw_ma_ff)] == $past(mr_wdata))
        else $error("register write lost during refresh");
    a_abort_cancel: assert property (is_srx && abort_on
        |=> !refresh_busy && $stable(refresh_count))
        else $error("abort did not cancel refresh");
    a_abort_density: assert property (!abort_on)
        else $error("abort enabled on small part");
    a_extra_ref: assert property (is_srx |=> extra_ref_needed [*2])
        else $error("extra refresh flag not set on exit");

endmodule : lp4_mr_sr

`default_nettype wire

// ==== lp4_ctrl_model.sv ====
// Controller model that drives the command pins of the mode register and self refresh unit.
`timescale 1ns/1ps
`default_nettype none
`include "lp4_mr_sr_map.svh"

module lp4_ctrl_model (
    // Clock.
    input  wire logic                        clk,
    // Command pins towards the unit.
    output var  lp4_mr_sr_pkg::cmd_pins_type cmd_pins
);
    int cyc      = 0;
    int ready_at = 0;
    int xsr_at   = 0;
    bit need_ref = 1'b0;

    initial cmd_pins = 8'h80;

    always @(posedge clk) begin
        cyc <= cyc + 1;
    end

    // One command: first cycle with cs high, argument cycle, then deselect with moving ca.
    task automatic send(input logic [4:0] code, input logic flag, input logic [5:0] arg,
                        input int gap);
        while (cyc < ready_at) @(posedge clk);
        @(posedge clk);
        cmd_pins <= {2'b11, flag, code};
        @(posedge clk);
        cmd_pins <= {2'b10, arg};
        @(posedge clk);
        cmd_pins <= {2'b10, ~arg};
        ready_at = cyc + gap + 1;
    endtask : send

    task automatic mrw(input logic [5:0] a, input logic [7:0] d);
        send(`CMD_MRW1, d[7], a, 0);
        send(`CMD_MRW2, d[6], d[5:0], 10);
    endtask : mrw

    // Only deselect follows until the whole burst has gone.
    task automatic mrr(input logic [5:0] a);
        send(`CMD_MRR1, 1'b0, a, 0);
        send(`CMD_CAS2, 1'b0, 6'h00, 40);
    endtask : mrr

    task automatic refresh(input logic all_bank);
        while (cyc < xsr_at) @(posedge clk);
        if (all_bank) begin
            send(`CMD_REF, 1'b1, 6'h00, 56);
        end else begin
            for (int b = 0; b < 8; b++) send(`CMD_REF, 1'b0, 6'(b), 18);
        end
        need_ref = 1'b0;
    endtask : refresh

    task automatic sre();
        if (need_ref) refresh(1'b1);
        send(`CMD_SRE, 1'b0, 6'h00, 4);
    endtask : sre

    task automatic srx();
        send(`CMD_SRX, 1'b0, 6'h00, 0);
        xsr_at   = cyc + 60;
        need_ref = 1'b1;
    endtask : srx
endmodule : lp4_ctrl_model
`default_nettype wire

// ==== lp4_mr_sr_tb.sv ====
// Self-checking testbench of the mode register and self refresh unit.
`timescale 1ns/1ps
`default_nettype none
`include "lp4_mr_sr_map.svh"

module lp4_mr_sr_tb;
    logic                        clk     = 1'b0;
    logic                        sys_rst = 1'b1;
    lp4_mr_sr_pkg::cmd_pins_type cmd_pins;
    lp4_mr_sr_pkg::rd_bus_type   rd_bus;
    logic                        in_self_refresh;
    logic                        refresh_busy;
    logic [15:0]                 refresh_count;
    logic                        extra_ref_needed;
    int                          miscompares = 0;
    int                          checks      = 0;
    int                          mr_model [64];
    int                          n;
    int                          a;
    logic [15:0]                 cnt0;

    always #2.5 clk = ~clk;

    lp4_mr_sr i_lp4_mr_sr (
        .clk              (clk),
        .sys_rst          (sys_rst),
        .cmd_pins         (cmd_pins),
        .rd_bus           (rd_bus),
        .in_self_refresh  (in_self_refresh),
        .refresh_busy     (refresh_busy),
        .refresh_count    (refresh_count),
        .extra_ref_needed (extra_ref_needed)
    );

    lp4_ctrl_model i_lp4_ctrl_model (
        .clk      (clk),
        .cmd_pins (cmd_pins)
    );

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic test_done();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done

    // Registers 0 and 5 to 8 are read-only and keep their reset value.
    task automatic write_mr(input int wa, input logic [7:0] d);
        i_lp4_ctrl_model.mrw(6'(wa), d);
        if (!(wa == 0 || (wa >= 5 && wa <= 8))) mr_model[wa] = int'(d);
    endtask : write_mr

    task automatic read_mr(input int ra);
        logic [7:0] exp;
        int         w;
        logic       prev;
        exp = 8'(mr_model[ra]);
        w   = 0;
        i_lp4_ctrl_model.mrr(6'(ra));
        while (rd_bus.dqs_oe !== 1'b1 && w < 80) begin
            @(negedge clk);
            w++;
        end
        chk("preamble oe", 16'h0002, {14'h0, rd_bus.dqs_oe, rd_bus.dq_oe});
        prev = rd_bus.dqs;
        for (int b = 0; b < 16; b++) begin
            @(negedge clk);
            chk("dq_oe", 16'h0001, 16'(rd_bus.dq_oe));
            chk("dqs", {15'h0, ~prev}, 16'(rd_bus.dqs));
            chk("dmi", 16'h0002, {14'h0, rd_bus.dmi_oe, rd_bus.dmi});
            chk("mr dq", (b < 4) ? {8'h00, exp} : 16'h0000, rd_bus.dq);
            prev = rd_bus.dqs;
        end
        @(negedge clk);
        chk("postamble oe", 16'h0002, {14'h0, rd_bus.dqs_oe, rd_bus.dq_oe});
        @(negedge clk);
        chk("dqs_oe end", 16'h0000, 16'(rd_bus.dqs_oe));
    endtask : read_mr

    initial begin
        #100000;
        miscompares++;
        test_done();
    end

    initial begin
        void'($urandom(32'h5a80d246));
        foreach (mr_model[i]) mr_model[i] = 0;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 6; i++) begin
            a = (i == 5) ? 63 : 9 + int'($urandom_range(53));
            write_mr(a, 8'($urandom));
            read_mr(a);
        end
        read_mr(a);
        $display("test register read write done");
        for (int i = 0; i < 5; i++) begin
            a = (i == 0) ? 0 : i + 4;
            write_mr(a, 8'($urandom_range(255, 1)));
            read_mr(a);
        end
        $display("test read-only registers done");
        write_mr(4, 8'h08);
        cnt0 = refresh_count;
        i_lp4_ctrl_model.sre();
        repeat (4) @(negedge clk);
        chk("in self refresh", 16'h0001, 16'(in_self_refresh));
        n = 0;
        while (refresh_busy !== 1'b1 && n < 1000) begin
            @(negedge clk);
            n++;
        end
        chk("refresh start", {15'h0, 1'b1} + cnt0, 16'(refresh_busy) + refresh_count);
        i_lp4_ctrl_model.srx();
        repeat (4) @(negedge clk);
        chk("exit flags", 16'h0001, {14'h0, in_self_refresh, extra_ref_needed});
        write_mr(4, 8'h0c);
        read_mr(4);
        n = 0;
        while (refresh_busy !== 1'b0 && n < 100) begin
            @(negedge clk);
            n++;
        end
        chk("refresh count", cnt0 + ((`DENSITY_GB >= `ABORT_MIN_GB) ? 16'h0 : 16'h1),
            refresh_count);
        i_lp4_ctrl_model.refresh(1'b1);
        repeat (4) @(negedge clk);
        chk("all-bank extra", 16'h0000, 16'(extra_ref_needed));
        i_lp4_ctrl_model.sre();
        repeat (8) @(negedge clk);
        i_lp4_ctrl_model.srx();
        repeat (4) @(negedge clk);
        chk("second exit", 16'h0001, 16'(extra_ref_needed));
        i_lp4_ctrl_model.refresh(1'b0);
        repeat (4) @(negedge clk);
        chk("per-bank extra", 16'h0000, 16'(extra_ref_needed));
        $display("test self refresh done");
        test_done();
    end
endmodule : lp4_mr_sr_tb
`default_nettype wire
